// *** verilog/pis_top.sv ***
// PWM interrupt status block: raw flags, enable mask, masked view, clear
//
// Functional notes
// - Timer 0 period match sets its raw flag regardless of enable.
// - Each timer 0..2 zero-count event sets its own raw flag.
// - Each timer 0..2 stop sets its own raw flag.
// - Masked status reads at 0x118, 32-bit read-only, zero after reset.
// - Capture channels 0..2 each have a masked status bit.
// - One-shot trip on outputs 0..2 each have a masked status bit.
// - Cycle-by-cycle trip on outputs 0..2 each have a masked bit.
// - Operator 0..2 B-side trip events each have a masked bit.
// - Operator 0..2 A-side trip events each have a masked bit.
// - Fault inputs 0..2 ending each have a masked bit.
// - Fault inputs beginning each have a masked bit.
// - Writing one to a clear bit drops raw and masked flags, unless an event sets that bit in the same cycle.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pis_top (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire pis_pkg::pis_events_s events,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   output logic irq
);
   // ***************************************************************
   // Register select
   // ***************************************************************
   typedef enum logic [2:0] {
      PIS_SEL_NONE = 3'b000,
      PIS_SEL_ENABLE = 3'b001,
      PIS_SEL_RAW = 3'b010,
      PIS_SEL_MASKED = 3'b011,
      PIS_SEL_CLEAR = 3'b100
   } pis_sel_e;

   // Unmapped addresses decode to none, so stray writes change nothing
   function automatic pis_sel_e decode_reg(input logic [11:0] a);
      pis_sel_e s;
      if (a == pis_pkg::OFS_IRQ_ENABLE) begin
         s = PIS_SEL_ENABLE;
      end else if (a == pis_pkg::OFS_RAW_STATUS) begin
         s = PIS_SEL_RAW;
      end else if (a == pis_pkg::OFS_MASKED_STATUS) begin
         s = PIS_SEL_MASKED;
      end else if (a == pis_pkg::OFS_IRQ_CLEAR) begin
         s = PIS_SEL_CLEAR;
      end else begin
         s = PIS_SEL_NONE;
      end
      return s;
   endfunction

   // ***************************************************************
   // Event packing
   // ***************************************************************
   // Events are same-clock one-cycle strobes, so no synchroniser is needed
   function automatic logic [31:0] pack_events(input pis_pkg::pis_events_s e);
      logic [31:0] v;
      v = 32'h0000_0000;

      v[pis_pkg::BIT_TIMER_HALT + 0] = e.timer_halt_event[0];
      v[pis_pkg::BIT_TIMER_HALT + 1] = e.timer_halt_event[1];
      v[pis_pkg::BIT_TIMER_HALT + 2] = e.timer_halt_event[2];

      v[pis_pkg::BIT_TIMER_ZERO + 0] = e.timer_zero_event[0];
      v[pis_pkg::BIT_TIMER_ZERO + 1] = e.timer_zero_event[1];
      v[pis_pkg::BIT_TIMER_ZERO + 2] = e.timer_zero_event[2];

      v[pis_pkg::BIT_TIMER_PERIOD + 0] = e.timer_period_match_event[0];
      v[pis_pkg::BIT_TIMER_PERIOD + 1] = e.timer_period_match_event[1];
      v[pis_pkg::BIT_TIMER_PERIOD + 2] = e.timer_period_match_event[2];

      v[pis_pkg::BIT_FAULT_BEGIN + 0] = e.fault_begin_event[0];
      v[pis_pkg::BIT_FAULT_BEGIN + 1] = e.fault_begin_event[1];
      v[pis_pkg::BIT_FAULT_BEGIN + 2] = e.fault_begin_event[2];

      v[pis_pkg::BIT_FAULT_END + 0] = e.fault_end_event[0];
      v[pis_pkg::BIT_FAULT_END + 1] = e.fault_end_event[1];
      v[pis_pkg::BIT_FAULT_END + 2] = e.fault_end_event[2];

      v[pis_pkg::BIT_TRIP_A + 0] = e.operator_trip_a_event[0];
      v[pis_pkg::BIT_TRIP_A + 1] = e.operator_trip_a_event[1];
      v[pis_pkg::BIT_TRIP_A + 2] = e.operator_trip_a_event[2];

      v[pis_pkg::BIT_TRIP_B + 0] = e.operator_trip_b_event[0];
      v[pis_pkg::BIT_TRIP_B + 1] = e.operator_trip_b_event[1];
      v[pis_pkg::BIT_TRIP_B + 2] = e.operator_trip_b_event[2];

      v[pis_pkg::BIT_CBC + 0] = e.cycle_by_cycle_trip[0];
      v[pis_pkg::BIT_CBC + 1] = e.cycle_by_cycle_trip[1];
      v[pis_pkg::BIT_CBC + 2] = e.cycle_by_cycle_trip[2];

      v[pis_pkg::BIT_OST + 0] = e.one_shot_trip[0];
      v[pis_pkg::BIT_OST + 1] = e.one_shot_trip[1];
      v[pis_pkg::BIT_OST + 2] = e.one_shot_trip[2];

      v[pis_pkg::BIT_CAPTURE + 0] = e.capture_event[0];
      v[pis_pkg::BIT_CAPTURE + 1] = e.capture_event[1];
      v[pis_pkg::BIT_CAPTURE + 2] = e.capture_event[2];

      return v;
   endfunction

   // ***************************************************************
   // Flag helpers
   // ***************************************************************
   // Set wins: a clear that lands with a new event must not lose it
   function automatic logic [2:0] group_next(
      input logic [2:0] cur,
      input logic [2:0] set,
      input logic [2:0] clr
   );
      return (cur & ~clr) | set;
   endfunction

   function automatic logic [31:0] clear_bits(
      input logic wr,
      input pis_sel_e sel,
      input logic [31:0] d
   );
      logic [31:0] v;
      v = 32'h0000_0000;
      if (wr && sel == PIS_SEL_CLEAR) begin
         v = d & pis_pkg::USED_BITS;
      end
      return v;
   endfunction

   // Unused bits never latch, so they cannot hold the line high
   function automatic logic [31:0] enable_next(
      input logic [31:0] cur,
      input logic wr,
      input pis_sel_e sel,
      input logic [31:0] d
   );
      logic [31:0] v;
      v = cur;
      if (wr && sel == PIS_SEL_ENABLE) begin
         v = d & pis_pkg::USED_BITS;
      end
      return v;
   endfunction

   function automatic logic [31:0] masked_view(
      input logic [31:0] raw,
      input logic [31:0] en
   );
      return raw & en;
   endfunction

   // Reads see the state before this cycle's updates
   function automatic logic [31:0] read_word(
      input logic rd,
      input pis_sel_e sel,
      input logic [31:0] raw,
      input logic [31:0] en
   );
      logic [31:0] v;
      v = pis_pkg::READ_UNMAPPED;
      if (rd) begin
         if (sel == PIS_SEL_ENABLE) begin
            v = en;
         end else if (sel == PIS_SEL_RAW) begin
            v = raw;
         end else if (sel == PIS_SEL_MASKED) begin
            v = masked_view(raw, en);
         end else begin
            // Clear register is write-only and reads zero
            v = pis_pkg::READ_UNMAPPED;
         end
      end
      return v;
   endfunction

   pis_pkg::pis_state_s state;
   pis_pkg::pis_state_s next_state;
   pis_sel_e sel;
   logic [31:0] set_vec;
   logic [31:0] clr_vec;
   logic [31:0] masked;

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      next_state = state;
      sel = decode_reg(addr);
      set_vec = pack_events(events);
      clr_vec = clear_bits(wr_stb, sel, wdata);

      next_state.raw[pis_pkg::BIT_TIMER_HALT +: 3] = group_next(
         state.raw[pis_pkg::BIT_TIMER_HALT +: 3],
         set_vec[pis_pkg::BIT_TIMER_HALT +: 3],
         clr_vec[pis_pkg::BIT_TIMER_HALT +: 3]);

      next_state.raw[pis_pkg::BIT_TIMER_ZERO +: 3] = group_next(
         state.raw[pis_pkg::BIT_TIMER_ZERO +: 3],
         set_vec[pis_pkg::BIT_TIMER_ZERO +: 3],
         clr_vec[pis_pkg::BIT_TIMER_ZERO +: 3]);

      next_state.raw[pis_pkg::BIT_TIMER_PERIOD +: 3] = group_next(
         state.raw[pis_pkg::BIT_TIMER_PERIOD +: 3],
         set_vec[pis_pkg::BIT_TIMER_PERIOD +: 3],
         clr_vec[pis_pkg::BIT_TIMER_PERIOD +: 3]);

      next_state.raw[pis_pkg::BIT_FAULT_BEGIN +: 3] = group_next(
         state.raw[pis_pkg::BIT_FAULT_BEGIN +: 3],
         set_vec[pis_pkg::BIT_FAULT_BEGIN +: 3],
         clr_vec[pis_pkg::BIT_FAULT_BEGIN +: 3]);

      next_state.raw[pis_pkg::BIT_FAULT_END +: 3] = group_next(
         state.raw[pis_pkg::BIT_FAULT_END +: 3],
         set_vec[pis_pkg::BIT_FAULT_END +: 3],
         clr_vec[pis_pkg::BIT_FAULT_END +: 3]);

      next_state.raw[pis_pkg::BIT_TRIP_A +: 3] = group_next(
         state.raw[pis_pkg::BIT_TRIP_A +: 3],
         set_vec[pis_pkg::BIT_TRIP_A +: 3],
         clr_vec[pis_pkg::BIT_TRIP_A +: 3]);

      next_state.raw[pis_pkg::BIT_TRIP_B +: 3] = group_next(
         state.raw[pis_pkg::BIT_TRIP_B +: 3],
         set_vec[pis_pkg::BIT_TRIP_B +: 3],
         clr_vec[pis_pkg::BIT_TRIP_B +: 3]);

      next_state.raw[pis_pkg::BIT_CBC +: 3] = group_next(
         state.raw[pis_pkg::BIT_CBC +: 3],
         set_vec[pis_pkg::BIT_CBC +: 3],
         clr_vec[pis_pkg::BIT_CBC +: 3]);

      next_state.raw[pis_pkg::BIT_OST +: 3] = group_next(
         state.raw[pis_pkg::BIT_OST +: 3],
         set_vec[pis_pkg::BIT_OST +: 3],
         clr_vec[pis_pkg::BIT_OST +: 3]);

      next_state.raw[pis_pkg::BIT_CAPTURE +: 3] = group_next(
         state.raw[pis_pkg::BIT_CAPTURE +: 3],
         set_vec[pis_pkg::BIT_CAPTURE +: 3],
         clr_vec[pis_pkg::BIT_CAPTURE +: 3]);

      // Top two bits have no source and stay clear
      next_state.raw[31:30] = 2'b00;

      next_state.enable = enable_next(state.enable, wr_stb, sel, wdata);

      masked = masked_view(next_state.raw, next_state.enable);
      next_state.irq = |masked;

      next_state.rdata = read_word(rd_stb, sel, state.raw, state.enable);
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state.raw <= pis_pkg::RESET_STATUS;
         state.enable <= pis_pkg::RESET_ENABLE;
         state.rdata <= pis_pkg::READ_UNMAPPED;
         state.irq <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   assign rdata = state.rdata;
   assign irq = state.irq;
endmodule // pis_top
`default_nettype wire

// *** verilog/pis_pkg.sv ***
// Package for the PWM interrupt status block: offsets, bit layout, reset values
`default_nettype none
package pis_pkg;
   // ***************************************************************
   // Register map (byte addresses)
   // ***************************************************************
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h110;
   localparam logic [11:0] OFS_RAW_STATUS = 12'h114;
   localparam logic [11:0] OFS_MASKED_STATUS = 12'h118;
   localparam logic [11:0] OFS_IRQ_CLEAR = 12'h11c;
   localparam logic [31:0] RESET_STATUS = 32'h0000_0000;
   localparam logic [31:0] RESET_ENABLE = 32'h0000_0000;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

   // ***************************************************************
   // Bit positions of the event sources
   // ***************************************************************
   localparam int BIT_TIMER_HALT = 0;
   localparam int BIT_TIMER_ZERO = 3;
   localparam int BIT_TIMER_PERIOD = 6;
   localparam int BIT_FAULT_BEGIN = 9;
   localparam int BIT_FAULT_END = 12;
   localparam int BIT_TRIP_A = 15;
   localparam int BIT_TRIP_B = 18;
   localparam int BIT_CBC = 21;
   localparam int BIT_OST = 24;
   localparam int BIT_CAPTURE = 27;
   localparam logic [31:0] USED_BITS = 32'h3fff_ffff;

   typedef struct packed {
      logic [2:0] timer_period_match_event;
      logic [2:0] timer_zero_event;
      logic [2:0] timer_halt_event;
      logic [2:0] fault_begin_event;
      logic [2:0] fault_end_event;
      logic [2:0] operator_trip_a_event;
      logic [2:0] operator_trip_b_event;
      logic [2:0] cycle_by_cycle_trip;
      logic [2:0] one_shot_trip;
      logic [2:0] capture_event;
   } pis_events_s;

   typedef struct packed {
      logic [31:0] raw;
      logic [31:0] enable;
      logic [31:0] rdata;
      logic irq;
   } pis_state_s;
endpackage : pis_pkg
`default_nettype wire

// *** verif/pis_chk.sv ***
// Checker for the PWM interrupt status block
`timescale 1ns/1ps
`default_nettype none
module pis_chk (
   input wire logic mclk, reset_n, clk_en,
   input wire pis_pkg::pis_events_s events,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb, rd_stb,
   input wire logic [31:0] rdata,
   input wire logic irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence raw_rd;
      clk_en && rd_stb && addr == pis_pkg::OFS_RAW_STATUS;
   endsequence
   // No event and no write: nothing may move the line
   sequence quiet;
      clk_en && events == '0 && !wr_stb;
   endsequence
   property raw_p(e, int b);
      clk_en && e ##1 raw_rd |=> rdata[b];
   endproperty
   period_raw_a: assert property (raw_p(events.timer_period_match_event[0], 6))
      else $error("period flag missing");
   zero_raw_a: assert property (raw_p(events.timer_zero_event[2], 5))
      else $error("zero flag missing");
   halt_raw_a: assert property (raw_p(events.timer_halt_event[1], 1))
      else $error("halt flag missing");
   reset_zero_a: assert property ($rose(reset_n) |-> !irq && rdata == 32'h0)
      else $error("outputs not clear after reset");
   rd_idle_a: assert property (clk_en && !rd_stb |=> rdata == 32'h0)
      else $error("read data without read");
   hi_bits_a: assert property (clk_en && rd_stb |=> rdata[31:30] == 2'b00)
      else $error("unused bits set");
   // Bulk clear with no event in flight
   sequence clear_all;
      clk_en && wr_stb && events == '0 && addr == pis_pkg::OFS_IRQ_CLEAR && wdata[29:0] == '1;
   endsequence
   clear_all_a: assert property (clear_all ##1 raw_rd |=> rdata == 32'h0)
      else $error("clear left raw flags");
   freeze_hold_a: assert property (!clk_en |=> $stable(irq) && $stable(rdata))
      else $error("state moved while frozen");
   clear_irq_a: assert property (clk_en && wr_stb && addr == pis_pkg::OFS_IRQ_CLEAR &&
      wdata[29:0] == '1 && events == '0 |=> !irq) else $error("clear left line high");
   irq_hold_a: assert property (quiet |=> $stable(irq))
      else $error("line moved without cause");
   mask_view_a: assert property (quiet ##0 rd_stb && addr == pis_pkg::OFS_MASKED_STATUS
      |=> (|rdata) == irq) else $error("line and masked view differ");
endmodule // pis_chk
`default_nettype wire

// *** verif/pis_top_tb.sv ***
// Testbench for the PWM interrupt status block
`timescale 1ns/1ps
`default_nettype none
module pis_top_tb;
   logic mclk = 0, reset_n = 0, clk_en = 1, wr_stb = 0, rd_stb = 0, irq;
   pis_pkg::pis_events_s events = '0;
   logic [11:0] addr = '0;
   logic [31:0] wdata = '0, rdata;
   int num_errors = 0, n_compared = 0, cyc = 0;
   pis_top pis_top_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .events(events),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));
   initial forever #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         close_out();
      end
   end
   task automatic chk(logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [11:0] a, logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic pulse(logic [29:0] v);
      @(posedge mclk);
      events <= pis_pkg::pis_events_s'(v);
      @(posedge mclk);
      events <= '0;
   endtask
   task automatic t_sources;
      int rb;
      for (int i = 0; i < 30; i++) begin
         rb = (i / 3 < 7 ? 27 - 3 * (i / 3) : 3 * (i / 3) - 21) + i % 3;
         pulse(30'h1 << i);
         rd(pis_pkg::OFS_RAW_STATUS, 32'h1 << rb);
         rd(pis_pkg::OFS_MASKED_STATUS, 32'h0);
         wr(pis_pkg::OFS_IRQ_ENABLE, 32'h1 << rb);
         rd(pis_pkg::OFS_MASKED_STATUS, 32'h1 << rb);
         chk({31'h0, irq}, 32'h1);
         wr(pis_pkg::OFS_IRQ_CLEAR, 32'h1 << rb);
         rd(pis_pkg::OFS_RAW_STATUS, 32'h0);
         chk({31'h0, irq}, 32'h0);
      end
   endtask
   // Status is read-only; every source at once, then one bulk clear
   task automatic t_guard;
      wr(pis_pkg::OFS_MASKED_STATUS, 32'hffff_ffff);
      rd(pis_pkg::OFS_RAW_STATUS, 32'h0);
      rd(12'h200, 32'h0);
      pulse(30'h3fff_ffff);
      rd(pis_pkg::OFS_RAW_STATUS, 32'h3fff_ffff);
      wr(pis_pkg::OFS_IRQ_ENABLE, 32'hffff_ffff);
      rd(pis_pkg::OFS_MASKED_STATUS, 32'h3fff_ffff);
      chk({31'h0, irq}, 32'h1);
      wr(pis_pkg::OFS_IRQ_CLEAR, 32'h3fff_ffff);
      rd(pis_pkg::OFS_MASKED_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask
   // Events and writes while the clock enable is low must leave no trace
   task automatic t_freeze;
      @(posedge mclk);
      clk_en <= 1'b0;
      pulse(30'h3fff_ffff);
      wr(pis_pkg::OFS_IRQ_ENABLE, 32'hffff_ffff);
      clk_en <= 1'b1;
      rd(pis_pkg::OFS_RAW_STATUS, 32'h0);
      rd(pis_pkg::OFS_IRQ_ENABLE, 32'h0000_0100);
   endtask
   task automatic close_out;
      if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      rd(pis_pkg::OFS_MASKED_STATUS, 32'h0);
      t_sources();
      t_freeze();
      t_guard();
      close_out();
   end
endmodule // pis_top_tb
bind pis_top pis_chk pis_chk_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
   .events(events), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rdata(rdata), .irq(irq));
`default_nettype wire
